// ===== rtl/mcr_pkg.sv
// Constants and types for the second modem control register block
package mcr_pkg;
   // Register addresses on the two bus ports
   localparam logic [2:0] MCR_CTRL_LOCAL_ADDR = 3'h1;
   localparam logic [3:0] MCR_CTRL_HOST_ADDR  = 4'h9;
   localparam logic [2:0] MCR_DET_LOCAL_ADDR  = 3'h2;
   localparam logic [3:0] MCR_DET_HOST_ADDR   = 4'ha;

   // Field positions in the control register
   localparam int MCR_TEST_LSB   = 0;
   localparam int MCR_SRST_BIT   = 2;
   localparam int MCR_CLKSEL_BIT = 3;
   localparam int MCR_BYPASS_BIT = 4;
   localparam int MCR_DETIE_BIT  = 5;
   localparam int MCR_PAT_LSB    = 6;

   // Detect status bit positions
   localparam int MCR_DET_CALLPROG = 1;
   localparam int MCR_DET_ANSWER   = 2;
   localparam int MCR_DET_CARRIER  = 3;
   localparam int MCR_DET_MARKS    = 4;

   // Reset values
   localparam logic [7:0] MCR_CTRL_RESET = 8'h00;
   localparam logic [7:0] MCR_RDATA_RESET = 8'h00;

   // Test mode codes
   typedef enum logic [1:0] {
      MCR_TEST_NORMAL  = 2'h0,
      MCR_TEST_ALOOP   = 2'h1,
      MCR_TEST_RDLOOP  = 2'h2,
      MCR_TEST_HDUPLEX = 2'h3
   } mcr_test_type;

   // Transmit pattern codes
   typedef enum logic [1:0] {
      MCR_PAT_DATA  = 2'h0,
      MCR_PAT_ALT   = 2'h1,
      MCR_PAT_MARK  = 2'h2,
      MCR_PAT_SPACE = 2'h3
   } mcr_pat_type;
endpackage : mcr_pkg

// ===== rtl/mcr_detect_irq.sv
// Detect interrupt pending flag with change detection and masking
`timescale 1ns/1ns
module mcr_detect_irq
   import mcr_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [4:1] detect_in,
   input  wire logic       irq_enable_in,
   input  wire logic       tx_enable_in,
   input  wire logic       dtmf_active_in,
   input  wire logic       power_down_in,
   input  wire logic       status_read_in,
   output logic            irq_out
);
   logic [4:1] prev;
   logic [4:1] next_prev;
   logic       next_irq;
   logic [4:1] change;
   logic       set_evt;

   // Masked change detection and pending flag update
   always_comb begin
      change    = detect_in ^ prev;
      if (tx_enable_in) begin
         change[MCR_DET_CALLPROG] = 1'b0;
         change[MCR_DET_ANSWER]   = 1'b0;
      end
      if (dtmf_active_in) begin
         change[MCR_DET_CARRIER] = 1'b0;
      end
      set_evt   = irq_enable_in && !power_down_in && |change;
      next_prev = detect_in;
      if (!irq_enable_in || power_down_in) begin
         next_irq = 1'b0;
      end else if (set_evt) begin
         next_irq = 1'b1;                                 // Set wins
      end else if (status_read_in) begin
         next_irq = 1'b0;
      end else begin
         next_irq = irq_out;
      end
   end

   // Registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prev    <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         prev    <= next_prev;
         irq_out <= next_irq;
      end
   end

   a_change_sets: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (irq_enable_in && !power_down_in && !tx_enable_in && !dtmf_active_in
       && (detect_in != prev)) |=> irq_out)
      else $error("Detect change did not raise interrupt");

   a_power_blocks: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      power_down_in |=> !irq_out)
      else $error("Interrupt pending during power down");

   a_read_clears: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (status_read_in && (detect_in == prev)) |=> !irq_out)
      else $error("Status read did not clear interrupt");

   a_tx_masks_tone: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (!irq_out && tx_enable_in && !dtmf_active_in
       && (detect_in[4:3] == prev[4:3])) |=> !irq_out)
      else $error("Masked tone change raised interrupt");
endmodule : mcr_detect_irq

// ===== rtl/mcr_top.sv
// Second modem control register and the datapath controls it steers
`timescale 1ns/1ns
module mcr_top
   import mcr_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       port_mode_select_in,
   input  wire logic [2:0] local_bus_addr_in,
   input  wire logic [3:0] host_bus_addr_in,
   input  wire logic       bus_wr_in,
   input  wire logic       bus_rd_in,
   input  wire logic [7:0] bus_wdata_in,
   output logic      [7:0] bus_rdata_out,
   input  wire logic       tx_enable_in,
   input  wire logic       power_on_in,
   input  wire logic       dtmf_active_in,
   input  wire logic [4:0] detect_in,
   input  wire logic       xtal_echo_in,
   input  wire logic       baud16_in,
   input  wire logic       bit_tick_in,
   input  wire logic       uart_txd_in,
   input  wire logic       line_rxd_in,
   output logic            modem_txd_out,
   output logic            uart_rxd_out,
   output logic            clk_pin_out,
   output logic            analog_tx_en_out,
   output logic            analog_loopback_out,
   output logic            scrambler_bypass_out,
   output logic            modem_power_down_out,
   output logic            clear_ctrl_regs_out,
   output logic            dual_port_irq_out,
   output logic            single_port_irq_out
);
   // Synchroniser stages for pin inputs
   logic [6:0]  sync_a;
   logic [6:0]  sync_b;
   logic        port_mode;
   logic [4:0]  detect;
   logic        xtal;

   // Register bank state
   logic [7:0]  ctrl;
   logic [7:0]  next_ctrl;
   logic        next_clear;
   logic [7:0]  next_rdata;
   logic        ctrl_hit;
   logic        det_hit;
   logic        status_read;

   // Datapath state
   logic        alt_bit;
   logic        next_alt_bit;
   logic        next_txd;
   logic        next_uart_rxd;
   logic        next_clk_pin;
   logic        next_tx_en;
   logic        next_aloop;
   logic        next_bypass;
   logic        next_pd;
   logic        next_dual_irq;
   logic        next_single_irq;
   logic        irq_pending;
   logic        power_down;
   mcr_test_type test_mode;
   mcr_pat_type  pattern;

   // Address decode shared by both registers
   function automatic logic addr_match(input logic       mode,
                                       input logic [2:0] loc,
                                       input logic [3:0] host,
                                       input logic [2:0] want_loc,
                                       input logic [3:0] want_host);
      if (mode) begin
         addr_match = (host == want_host);
      end else begin
         addr_match = (loc == want_loc);
      end
   endfunction : addr_match

   // Two-stage synchroniser for mode strap, detectors and crystal
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
      end else begin
         sync_a <= {xtal_echo_in, detect_in, port_mode_select_in};
         sync_b <= sync_a;
      end
   end

   assign port_mode = sync_b[0];
   assign detect    = sync_b[5:1];
   assign xtal      = sync_b[6];

   // Bus decode
   assign ctrl_hit = addr_match(port_mode, local_bus_addr_in,
                                host_bus_addr_in, MCR_CTRL_LOCAL_ADDR,
                                MCR_CTRL_HOST_ADDR);
   assign det_hit  = addr_match(port_mode, local_bus_addr_in,
                                host_bus_addr_in, MCR_DET_LOCAL_ADDR,
                                MCR_DET_HOST_ADDR);
   assign status_read = bus_rd_in && det_hit;
   assign test_mode   = mcr_test_type'(ctrl[MCR_TEST_LSB +: 2]);
   assign pattern     = mcr_pat_type'(ctrl[MCR_PAT_LSB +: 2]);
   assign power_down  = !power_on_in || clear_ctrl_regs_out;

   // Register write, soft reset and read data
   always_comb begin
      next_ctrl  = ctrl;
      next_clear = 1'b0;
      next_rdata = bus_rdata_out;
      if (bus_wr_in && ctrl_hit) begin
         if (bus_wdata_in[MCR_SRST_BIT]) begin
            next_ctrl  = MCR_CTRL_RESET;
            next_clear = 1'b1;
         end else begin
            next_ctrl  = bus_wdata_in;
         end
      end
      if (bus_rd_in && ctrl_hit) begin
         next_rdata = ctrl;
      end else if (status_read) begin
         next_rdata = {3'h0, detect};
      end
   end

   // Register bank registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ctrl                <= MCR_CTRL_RESET;
         clear_ctrl_regs_out <= 1'b0;
         bus_rdata_out       <= MCR_RDATA_RESET;
      end else begin
         ctrl                <= next_ctrl;
         clear_ctrl_regs_out <= next_clear;
         bus_rdata_out       <= next_rdata;
      end
   end

   // Detect interrupt tracking
   mcr_detect_irq u_detect_irq (
      .sys_clk_in     (sys_clk_in),
      .rst_n_in       (rst_n_in),
      .detect_in      (detect[4:1]),
      .irq_enable_in  (ctrl[MCR_DETIE_BIT]),
      .tx_enable_in   (tx_enable_in),
      .dtmf_active_in (dtmf_active_in),
      .power_down_in  (power_down),
      .status_read_in (status_read),
      .irq_out        (irq_pending)
   );

   // Transmit source, loopbacks, clock pin and control outputs
   always_comb begin
      next_alt_bit = bit_tick_in ? !alt_bit : alt_bit;
      case (pattern)
         MCR_PAT_ALT:   next_txd = alt_bit;
         MCR_PAT_MARK:  next_txd = 1'b1;
         MCR_PAT_SPACE: next_txd = 1'b0;
         default: begin
            if (test_mode == MCR_TEST_RDLOOP) begin
               next_txd = line_rxd_in;
            end else begin
               next_txd = uart_txd_in;
            end
         end
      endcase
      case (test_mode)
         MCR_TEST_RDLOOP:  next_uart_rxd = 1'b1;
         MCR_TEST_HDUPLEX: next_uart_rxd = uart_txd_in && line_rxd_in;
         default:          next_uart_rxd = line_rxd_in;
      endcase
      next_aloop   = (test_mode == MCR_TEST_ALOOP);
      next_clk_pin = ctrl[MCR_CLKSEL_BIT] ? baud16_in : xtal;
      next_tx_en   = tx_enable_in && !power_down;
      next_bypass  = ctrl[MCR_BYPASS_BIT];
      next_pd      = power_down;
      next_dual_irq   = irq_pending && !port_mode;
      next_single_irq = irq_pending && port_mode;
   end

   // Datapath registers
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         alt_bit              <= 1'b0;
         modem_txd_out        <= 1'b1;
         uart_rxd_out         <= 1'b1;
         clk_pin_out          <= 1'b0;
         analog_tx_en_out     <= 1'b0;
         analog_loopback_out  <= 1'b0;
         scrambler_bypass_out <= 1'b0;
         modem_power_down_out <= 1'b1;
         dual_port_irq_out    <= 1'b0;
         single_port_irq_out  <= 1'b0;
      end else begin
         alt_bit              <= next_alt_bit;
         modem_txd_out        <= next_txd;
         uart_rxd_out         <= next_uart_rxd;
         clk_pin_out          <= next_clk_pin;
         analog_tx_en_out     <= next_tx_en;
         analog_loopback_out  <= next_aloop;
         scrambler_bypass_out <= next_bypass;
         modem_power_down_out <= next_pd;
         dual_port_irq_out    <= next_dual_irq;
         single_port_irq_out  <= next_single_irq;
      end
   end

   // Write with the reset bit, then the visible effects
   sequence s_soft_reset_write;
      bus_wr_in && ctrl_hit && bus_wdata_in[MCR_SRST_BIT];
   endsequence

   sequence s_soft_reset_effect;
      clear_ctrl_regs_out && (ctrl == 8'h00) ##1
      modem_power_down_out && (clk_pin_out == $past(xtal));
   endsequence

   a_soft_reset_clear: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      s_soft_reset_write |=> s_soft_reset_effect)
      else $error("Soft reset did not clear and power down");

   a_ctrl_write: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (bus_wr_in && ctrl_hit && !bus_wdata_in[MCR_SRST_BIT])
      |=> (ctrl == $past(bus_wdata_in)))
      else $error("Control write not stored");

   a_ctrl_readback: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (bus_rd_in && ctrl_hit) |=> (bus_rdata_out == $past(ctrl)))
      else $error("Control readback mismatch");

   a_remote_mark: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (test_mode == MCR_TEST_RDLOOP) |=> uart_rxd_out)
      else $error("Receive output not held at mark");

   a_half_duplex: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (test_mode == MCR_TEST_HDUPLEX)
      |=> (uart_rxd_out == ($past(uart_txd_in) && $past(line_rxd_in))))
      else $error("Half-duplex receive data wrong");

   a_clock_select: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      ctrl[MCR_CLKSEL_BIT] |=> (clk_pin_out == $past(baud16_in)))
      else $error("Clock pin not at rate clock");

   a_pattern_fixed: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (pattern == MCR_PAT_MARK) ##1 (pattern == MCR_PAT_SPACE)
      |=> !modem_txd_out && $past(modem_txd_out))
      else $error("Fixed transmit pattern wrong");

   a_txen_gate: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !tx_enable_in |=> !analog_tx_en_out)
      else $error("Analog transmit enabled without control");

   a_irq_route: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !(dual_port_irq_out && single_port_irq_out))
      else $error("Interrupt on both pins");

   a_normal_path: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      ((test_mode == MCR_TEST_NORMAL) && (pattern == MCR_PAT_DATA))
      |=> ((modem_txd_out == $past(uart_txd_in))
           && (uart_rxd_out == $past(line_rxd_in))))
      else $error("Normal path data wrong");

   a_analog_loop: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (test_mode == MCR_TEST_ALOOP) |=> analog_loopback_out)
      else $error("Analog loopback not selected");

   a_remote_data: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      ((test_mode == MCR_TEST_RDLOOP) && (pattern == MCR_PAT_DATA))
      |=> (modem_txd_out == $past(line_rxd_in)))
      else $error("Remote loopback data not sent");

   a_crystal_echo: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !ctrl[MCR_CLKSEL_BIT] |=> (clk_pin_out == $past(xtal)))
      else $error("Clock pin not at crystal echo");

   a_scrambler_bypass: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      ctrl[MCR_BYPASS_BIT] |=> scrambler_bypass_out)
      else $error("Scrambler bypass not applied");

   a_alt_pattern: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (pattern == MCR_PAT_ALT) |=> (modem_txd_out == $past(alt_bit)))
      else $error("Alternating pattern not sent");

   a_status_data: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      status_read |=> (bus_rdata_out == {3'h0, $past(detect)}))
      else $error("Detect status readback wrong");

   a_irq_single: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (irq_pending && port_mode) |=> single_port_irq_out)
      else $error("Single-port interrupt pin not raised");
endmodule : mcr_top

// ===== testbench/mcr_host_model.sv
// Host processor model that drives the register bus of the block
`timescale 1ns/1ns
module mcr_host_model (
   input  wire logic       sys_clk_in,
   input  wire logic [7:0] bus_rdata_in,
   output logic            port_mode_select_out,
   output logic      [2:0] local_bus_addr_out,
   output logic      [3:0] host_bus_addr_out,
   output logic            bus_wr_out,
   output logic            bus_rd_out,
   output logic      [7:0] bus_wdata_out,
   output logic            tx_enable_out
);
   // Idle bus at time zero
   initial begin
      port_mode_select_out = 1'b0;
      local_bus_addr_out   = 3'h0;
      host_bus_addr_out    = 4'h0;
      bus_wr_out           = 1'b0;
      bus_rd_out           = 1'b0;
      bus_wdata_out        = 8'h00;
      tx_enable_out        = 1'b0;
   end

   // One write; released data is inverted so stale values never match
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      local_bus_addr_out <= a[2:0];
      host_bus_addr_out  <= a;
      bus_wdata_out      <= d;
      bus_wr_out         <= 1'b1;
      @(posedge sys_clk_in);
      bus_wr_out    <= 1'b0;
      bus_wdata_out <= ~d;
   endtask : wr_reg

   // One read; data is taken once the registered answer has settled
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      local_bus_addr_out <= a[2:0];
      host_bus_addr_out  <= a;
      bus_rd_out         <= 1'b1;
      @(posedge sys_clk_in);
      bus_rd_out <= 1'b0;
      #1 d = bus_rdata_in;
   endtask : rd_reg

   // Port mode strap; waits out the synchroniser
   task automatic set_mode(input logic m);
      @(posedge sys_clk_in);
      port_mode_select_out <= m;
      repeat (4) @(posedge sys_clk_in);
   endtask : set_mode

   // Transmit enable of the first control register
   task automatic set_txen(input logic e);
      @(posedge sys_clk_in);
      tx_enable_out <= e;
   endtask : set_txen
endmodule : mcr_host_model

// ===== testbench/modem_control_reg_one_test.sv
// Self-checking bench for the second modem control register block
`timescale 1ns/1ns
module modem_control_reg_one_test
   import mcr_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] ins;
      logic [4:0] exp;
      logic [4:0] care;
   } mcr_row_type;
   // Inputs {txd, rxd, xtal, b16}; outputs {txd, rxd, clk, byp, aloop}
   localparam mcr_row_type ROWS [12] = '{
      '{8'h00, 4'ha, 5'h14, 5'h1f}, '{8'h00, 4'h5, 5'h08, 5'h1f},
      '{8'h08, 4'h5, 5'h0c, 5'h1f}, '{8'h18, 4'ha, 5'h12, 5'h1f},
      '{8'h01, 4'ha, 5'h05, 5'h07}, '{8'h02, 4'h5, 5'h18, 5'h1f},
      '{8'h02, 4'ha, 5'h0c, 5'h1f}, '{8'h03, 4'hc, 5'h08, 5'h0f},
      '{8'h03, 4'h8, 5'h00, 5'h0f}, '{8'h80, 4'h4, 5'h18, 5'h1f},
      '{8'hc0, 4'h9, 5'h00, 5'h1f}, '{8'h82, 4'h2, 5'h1c, 5'h1f}};
   logic       clk, rst_n, mode, wr, rd, txen, pwr_on, dtmf, first;
   logic       xtal, b16, tick, utxd, lrxd;
   logic       mtxd, urxd, clkp, atx, aloop, byp, pdn, clr, dirq, sirq;
   logic [2:0] laddr;
   logic [3:0] haddr;
   logic [7:0] wdata, rdata, rd_val;
   logic [4:0] det;
   int         fail_count, checks, cycles;

   mcr_host_model mcr_host_model_inst (
      .sys_clk_in(clk), .bus_rdata_in(rdata), .port_mode_select_out(mode),
      .local_bus_addr_out(laddr), .host_bus_addr_out(haddr),
      .bus_wr_out(wr), .bus_rd_out(rd), .bus_wdata_out(wdata),
      .tx_enable_out(txen));

   mcr_top mcr_top_inst (
      .sys_clk_in(clk), .rst_n_in(rst_n), .port_mode_select_in(mode),
      .local_bus_addr_in(laddr), .host_bus_addr_in(haddr),
      .bus_wr_in(wr), .bus_rd_in(rd), .bus_wdata_in(wdata),
      .bus_rdata_out(rdata), .tx_enable_in(txen), .power_on_in(pwr_on),
      .dtmf_active_in(dtmf), .detect_in(det), .xtal_echo_in(xtal),
      .baud16_in(b16), .bit_tick_in(tick), .uart_txd_in(utxd),
      .line_rxd_in(lrxd), .modem_txd_out(mtxd), .uart_rxd_out(urxd),
      .clk_pin_out(clkp), .analog_tx_en_out(atx),
      .analog_loopback_out(aloop), .scrambler_bypass_out(byp),
      .modem_power_down_out(pdn), .clear_ctrl_regs_out(clr),
      .dual_port_irq_out(dirq), .single_port_irq_out(sirq));

   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         conclude();
      end
   end

   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Change detect inputs, then look at both interrupt pins
   task automatic irq_case(input logic [4:0] d, input logic [1:0] exp);
      @(posedge clk);
      det <= d;
      repeat (10) @(posedge clk);
      #1 chk({6'h0, dirq, sirq}, {6'h0, exp});
   endtask : irq_case

   task automatic conclude();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      {clk, rst_n, dtmf, xtal, b16, tick, utxd, lrxd} = 8'h03;
      pwr_on = 1'b1;
      det = 5'h00;
      {fail_count, checks, cycles} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk({3'h0, mtxd, urxd, clkp, dirq, sirq}, 8'h18);
      chk(rdata, 8'h00);
      foreach (ROWS[i]) begin
         @(posedge clk);
         {utxd, lrxd, xtal, b16} <= ROWS[i].ins;
         mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, ROWS[i].ctrl);
         repeat (4) @(posedge clk);
         #1 chk({3'h0, {mtxd, urxd, clkp, byp, aloop} & ROWS[i].care},
                {3'h0, ROWS[i].exp & ROWS[i].care});
         mcr_host_model_inst.rd_reg(MCR_CTRL_HOST_ADDR, rd_val);
         chk(rd_val, ROWS[i].ctrl);
      end
      // Alternating pattern flips on each bit tick
      mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, 8'h40);
      repeat (3) @(posedge clk);
      #1 first = mtxd;
      repeat (2) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk({7'h0, mtxd}, {7'h0, ~first});
         first = ~first;
      end
      // Unmapped local address is ignored
      mcr_host_model_inst.wr_reg(4'h5, 8'hff);
      mcr_host_model_inst.rd_reg(MCR_CTRL_HOST_ADDR, rd_val);
      chk(rd_val, 8'h40);
      // Soft reset: one-cycle clear, power down, crystal on clock pin
      @(posedge clk) {xtal, b16} <= 2'b10;
      mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, 8'h3c);
      #1 chk({7'h0, clr}, 8'h01);
      @(posedge clk);
      #1 chk({6'h0, clr, pdn}, 8'h01);
      mcr_host_model_inst.rd_reg(MCR_CTRL_HOST_ADDR, rd_val);
      chk({rd_val[7:1], clkp}, 8'h01);
      // Analog transmit gating and power down
      mcr_host_model_inst.set_txen(1'b1);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, atx}, 8'h01);
      @(posedge clk) pwr_on <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({6'h0, atx, pdn}, 8'h01);
      @(posedge clk) pwr_on <= 1'b1;
      mcr_host_model_inst.set_txen(1'b0);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, atx, pdn}, 8'h00);
      // Detect interrupts in dual-port mode
      mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, 8'h20);
      irq_case(5'h01, 2'b00);
      irq_case(5'h09, 2'b10);
      mcr_host_model_inst.rd_reg(MCR_DET_HOST_ADDR, rd_val);
      chk(rd_val, 8'h09);
      irq_case(5'h09, 2'b00);
      mcr_host_model_inst.set_txen(1'b1);
      irq_case(5'h0b, 2'b00);
      irq_case(5'h0f, 2'b00);
      @(posedge clk) dtmf <= 1'b1;
      irq_case(5'h07, 2'b00);
      irq_case(5'h17, 2'b10);
      mcr_host_model_inst.rd_reg(MCR_DET_HOST_ADDR, rd_val);
      chk(rd_val, 8'h17);
      mcr_host_model_inst.set_txen(1'b0);
      @(posedge clk) dtmf <= 1'b0;
      pwr_on <= 1'b0;
      irq_case(5'h06, 2'b00);
      @(posedge clk) pwr_on <= 1'b1;
      mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, 8'h00);
      irq_case(5'h0e, 2'b00);
      // Single-port mode: other pin, host-side address only
      mcr_host_model_inst.set_mode(1'b1);
      mcr_host_model_inst.wr_reg(MCR_CTRL_HOST_ADDR, 8'h20);
      mcr_host_model_inst.wr_reg(4'h1, 8'h55);
      mcr_host_model_inst.rd_reg(MCR_CTRL_HOST_ADDR, rd_val);
      chk(rd_val, 8'h20);
      irq_case(5'h02, 2'b01);
      // Reset in mid-run clears the register
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({6'h0, dirq, sirq}, 8'h00);
      mcr_host_model_inst.rd_reg(MCR_CTRL_HOST_ADDR, rd_val);
      chk(rd_val, 8'h00);
      conclude();
   end
endmodule : modem_control_reg_one_test
